// file: design/dpc_defs.svh
// ---------------------------------------------------------------------------
// dpc_defs: constants for the converter pin control and serial port
// ---------------------------------------------------------------------------
// Purpose: offsets-free constant set (no bus) with field widths and timing
// Assumes: included by bare name from the design files
// Notes:   no register map; all control bits arrive as plain ports
//
// Summary of operation
// RULE_01 - master reset zeroes every internal register
// RULE_02 - edge select: low falling, high rising
// RULE_03 - one serial clock times both data directions
// RULE_04 - rising convert input starts one conversion
// RULE_05 - busy is high during conversion
// RULE_06 - select high drives internal oscillator out
// RULE_07 - select low makes conversion clock an input
// RULE_08 - three-wire mode never drives serial input
// RULE_09 - two-wire mode also drives serial input pin
// RULE_10 - serial output driven only while select low
// RULE_11 - serial output identical in both wire modes
// RULE_12 - chip select high ignores port, input released
// RULE_13 - conversions ignore chip select entirely
// RULE_14 - four general pins each input or output
// RULE_15 - converter clock is conversion clock over 1,2,4,8
// RULE_16 - one conversion takes fourteen divided clocks
// RULE_17 - oscillator enable bit acts like select high
// RULE_18 - host configures device through serial commands
// RULE_19 - busy rises at start, falls when result ready
// RULE_20 - host waits for busy low before triggering
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

`define DPC_CONV_CYCLES   5'h0E
`define DPC_GP_WIDTH      4
`define DPC_OSC_HALF      4'h2
`define DPC_DF_W          2
`define DPC_RESET_ZERO    1'b0

`endif

// file: design/dpc_pkg.sv
// ---------------------------------------------------------------------------
// dpc_pkg: types shared by the pin control block
// ---------------------------------------------------------------------------
// Purpose: state types
// Assumes: nothing
// Notes:   none
package dpc_pkg;
  typedef enum logic [1:0] {DPC_IDLE, DPC_CONV, DPC_DONE} dpc_conv_st_t;
endpackage

// file: design/dpc_clk_div.sv
// ---------------------------------------------------------------------------
// dpc_clk_div: divides the conversion clock by 1, 2, 4 or 8
// ---------------------------------------------------------------------------
// Purpose: produce a one-cycle tick per divided conversion clock period
// Assumes: i_conversion_clock_rise is a one-cycle pulse per conversion clock period
// Notes:   tick rather than a derived clock keeps one clock domain
`include "dpc_defs.svh"
module dpc_clk_div #(
  parameter int DF_W = `DPC_DF_W
) (
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_resetn,
  // control
  input  wire logic            i_conversion_clock_rise,
  input  wire logic [DF_W-1:0] i_div_factor,
  // divided tick
  output logic                 o_divided_conversion_clock_tick
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       tick_ff;
  logic       nxt_tick;
  logic [2:0] lim;

  // divide factor encodes 1<<sel; limit is factor minus one
  always_comb begin
    lim      = 3'((4'h1 << i_div_factor) - 4'h1);
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (i_conversion_clock_rise) begin
      if (cnt_ff >= lim) begin
        nxt_cnt  = 3'h0;
        nxt_tick = 1'b1; // RULE_15
      end else begin
        nxt_cnt  = 3'(cnt_ff + 3'h1);
      end
    end
  end

  // register divider state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_ff  <= 3'h0; // RULE_01
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign o_divided_conversion_clock_tick = tick_ff;
endmodule

// file: design/dpc_top.sv
// ---------------------------------------------------------------------------
// dpc_top: pin control, conversion sequencing and serial port pins
// ---------------------------------------------------------------------------
// Purpose: reset, convert/busy, conversion clock source, serial port pins
// Assumes: all inputs synchronous to I_CLK_SYS (10 MHz)
// Notes:   serial shifting is edge-detected on the sampled serial clock;
//          the command decoder is outside this block, words cross by ports
`include "dpc_defs.svh"
module dpc_top #(
  parameter int GP_W = `DPC_GP_WIDTH,
  parameter int DF_W = `DPC_DF_W,
  parameter int SW   = 8
) (
  // clock and reset
  input  wire logic            I_CLK_SYS,
  input  wire logic            I_RESETN,
  // conversion control
  input  wire logic            I_CONVERT,
  input  wire logic            I_CLOCK_SOURCE_SELECT,
  input  wire logic            I_OSCILLATOR_ENABLE_BIT,
  input  wire logic [DF_W-1:0] I_CLOCK_DIVIDE_FACTOR,
  output logic                 O_BUSY,
  // conversion clock pin
  input  wire logic            I_CONVERSION_CLOCK,
  output logic                 O_CONVERSION_CLOCK,
  output logic                 O_CONVERSION_CLOCK_OE,
  // serial port
  input  wire logic            I_CS_N,
  input  wire logic            I_EDGE_SELECT,
  input  wire logic            I_TWO_WIRE,
  input  wire logic            I_SCLK,
  input  wire logic            I_DIN,
  output logic                 O_DIN,
  output logic                 O_DIN_OE,
  output logic                 O_DOUT,
  output logic                 O_DOUT_OE,
  // serial words to and from the command logic
  input  wire logic [SW-1:0]   I_TX_WORD,
  output logic [SW-1:0]        O_RX_WORD,
  output logic                 O_RX_VALID,
  // general purpose pins
  input  wire logic [GP_W-1:0] I_GP_DIR_OUT,
  input  wire logic [GP_W-1:0] I_GP_OUT_VAL,
  input  wire logic [GP_W-1:0] I_GENERAL_PURPOSE_PINS,
  output logic [GP_W-1:0]      O_GENERAL_PURPOSE_PINS,
  output logic [GP_W-1:0]      O_GENERAL_PURPOSE_PINS_OE,
  output logic [GP_W-1:0]      O_GP_IN_VAL
);
  // -------------------------------------------------------------------------
  // conversion clock source
  // -------------------------------------------------------------------------
  logic       osc_on;
  logic [3:0] osc_cnt_ff, nxt_osc_cnt;
  logic       osc_ff, nxt_osc;
  logic       oe_ff, nxt_oe;
  logic       conversion_clock_q_ff, nxt_conversion_clock_q;
  logic       conversion_clock_rise;

  assign osc_on = I_CLOCK_SOURCE_SELECT | I_OSCILLATOR_ENABLE_BIT; // RULE_06 RULE_17

  // internal oscillator is a divided system clock; sequencer takes it from the register when driven, else from the pin
  always_comb begin
    nxt_osc_cnt = osc_cnt_ff;
    nxt_osc     = osc_ff;
    nxt_oe      = osc_on; // RULE_07
    if (!osc_on) begin
      nxt_osc_cnt = 4'h0;
      nxt_osc     = 1'b0;
    end else if (osc_cnt_ff == `DPC_OSC_HALF - 4'h1) begin
      nxt_osc_cnt = 4'h0;
      nxt_osc     = ~osc_ff; // RULE_06
    end else begin
      nxt_osc_cnt = 4'(osc_cnt_ff + 4'h1);
    end
    // pin value seen internally either way
    nxt_conversion_clock_q  = oe_ff ? osc_ff : I_CONVERSION_CLOCK;
  end

  assign conversion_clock_rise = nxt_conversion_clock_q & ~conversion_clock_q_ff;

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      osc_cnt_ff <= 4'h0; // RULE_01
      osc_ff     <= 1'b0;
      oe_ff      <= 1'b0;
      conversion_clock_q_ff  <= 1'b0;
    end else begin
      osc_cnt_ff <= nxt_osc_cnt;
      osc_ff     <= nxt_osc;
      oe_ff      <= nxt_oe;
      conversion_clock_q_ff  <= nxt_conversion_clock_q;
    end
  end

  assign O_CONVERSION_CLOCK    = osc_ff;
  assign O_CONVERSION_CLOCK_OE = oe_ff;

  // -------------------------------------------------------------------------
  // conversion sequencer
  // -------------------------------------------------------------------------
  logic                  divided_conversion_clock_tick;
  dpc_pkg::dpc_conv_st_t st_ff, nxt_st;
  logic [4:0]            cyc_ff, nxt_cyc;
  logic                  conv_q_ff;
  logic                  busy_ff, nxt_busy;

  dpc_clk_div #(.DF_W(DF_W)) u_div (
    .i_clk        (I_CLK_SYS),
    .i_resetn     (I_RESETN),
    .i_conversion_clock_rise  (conversion_clock_rise),
    .i_div_factor (I_CLOCK_DIVIDE_FACTOR),
    .o_divided_conversion_clock_tick  (divided_conversion_clock_tick)
  );

  // chip select deliberately absent here: conversions run regardless
  always_comb begin
    nxt_st   = st_ff;
    nxt_cyc  = cyc_ff;
    unique case (st_ff)
      dpc_pkg::DPC_IDLE: begin
        if (I_CONVERT && !conv_q_ff) begin // RULE_04 RULE_13
          nxt_st  = dpc_pkg::DPC_CONV;
          nxt_cyc = 5'h0;
        end
      end
      dpc_pkg::DPC_CONV: begin
        if (divided_conversion_clock_tick) begin
          nxt_cyc = 5'(cyc_ff + 5'h1);
          if (cyc_ff == `DPC_CONV_CYCLES - 5'h1) begin
            nxt_st = dpc_pkg::DPC_DONE; // RULE_16
          end
        end
      end
      dpc_pkg::DPC_DONE: begin
        nxt_st = dpc_pkg::DPC_IDLE; // done lasts one cycle, then back to idle
      end
      default: nxt_st = dpc_pkg::DPC_IDLE;
    endcase
    nxt_busy = (nxt_st == dpc_pkg::DPC_CONV); // RULE_05 RULE_19
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_ff     <= dpc_pkg::DPC_IDLE; // RULE_01
      cyc_ff    <= 5'h0;
      conv_q_ff <= 1'b0;
      busy_ff   <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      cyc_ff    <= nxt_cyc;
      conv_q_ff <= I_CONVERT;
      busy_ff   <= nxt_busy;
    end
  end

  assign O_BUSY = busy_ff;

  // -------------------------------------------------------------------------
  // serial port
  // -------------------------------------------------------------------------
  logic          sclk_q_ff;
  logic          act_edge;
  logic [SW-1:0] rx_sh_ff, nxt_rx_sh;
  logic [SW-1:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0]    bit_ff, nxt_bit;
  logic [SW-1:0] rx_word_ff, nxt_rx_word;
  logic          rx_vld_ff, nxt_rx_vld;
  logic          dout_ff, nxt_dout;
  logic          doe_ff, nxt_doe;
  logic          dinoe_ff, nxt_dinoe;

  // one serial clock, chosen edge, both directions
  assign act_edge = I_EDGE_SELECT ? (I_SCLK & ~sclk_q_ff)
                                  : (~I_SCLK & sclk_q_ff); // RULE_02 RULE_03

  always_comb begin
    nxt_rx_sh   = rx_sh_ff;
    nxt_tx_sh   = tx_sh_ff;
    nxt_bit     = bit_ff;
    nxt_rx_word = rx_word_ff;
    nxt_rx_vld  = 1'b0;
    nxt_dout    = dout_ff;
    nxt_doe     = ~I_CS_N; // RULE_10 RULE_11
    nxt_dinoe   = ~I_CS_N & I_TWO_WIRE; // RULE_08 RULE_09 RULE_12
    if (I_CS_N) begin
      nxt_bit   = 4'h0; // RULE_12
      nxt_tx_sh = I_TX_WORD;
      nxt_dout  = I_TX_WORD[SW-1];
    end else if (act_edge) begin
      nxt_rx_sh = {rx_sh_ff[SW-2:0], I_DIN};
      nxt_tx_sh = {tx_sh_ff[SW-2:0], 1'b0};
      nxt_dout  = tx_sh_ff[SW-2]; // RULE_03
      if (bit_ff == 4'(SW - 1)) begin
        nxt_bit     = 4'h0;
        nxt_rx_word = {rx_sh_ff[SW-2:0], I_DIN};
        nxt_rx_vld  = 1'b1;
        nxt_tx_sh   = I_TX_WORD;
        nxt_dout    = I_TX_WORD[SW-1];
      end else begin
        nxt_bit = 4'(bit_ff + 4'h1);
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sclk_q_ff  <= 1'b0; // RULE_01
      rx_sh_ff   <= '0;
      tx_sh_ff   <= '0;
      bit_ff     <= 4'h0;
      rx_word_ff <= '0;
      rx_vld_ff  <= 1'b0;
      dout_ff    <= 1'b0;
      doe_ff     <= 1'b0;
      dinoe_ff   <= 1'b0;
    end else begin
      sclk_q_ff  <= I_SCLK;
      rx_sh_ff   <= nxt_rx_sh;
      tx_sh_ff   <= nxt_tx_sh;
      bit_ff     <= nxt_bit;
      rx_word_ff <= nxt_rx_word;
      rx_vld_ff  <= nxt_rx_vld;
      dout_ff    <= nxt_dout;
      doe_ff     <= nxt_doe;
      dinoe_ff   <= nxt_dinoe;
    end
  end

  assign O_DOUT     = dout_ff;
  assign O_DOUT_OE  = doe_ff;
  assign O_DIN      = dout_ff; // same data as the dedicated output
  assign O_DIN_OE   = dinoe_ff;
  assign O_RX_WORD  = rx_word_ff;
  assign O_RX_VALID = rx_vld_ff;

  // -------------------------------------------------------------------------
  // general purpose pins
  // -------------------------------------------------------------------------
  logic [GP_W-1:0] gp_o_ff, gp_oe_ff, gp_in_ff;

  // each pin independently input or output
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      gp_o_ff  <= '0; // RULE_01
      gp_oe_ff <= '0;
      gp_in_ff <= '0;
    end else begin
      gp_o_ff  <= I_GP_OUT_VAL;
      gp_oe_ff <= I_GP_DIR_OUT; // RULE_14
      gp_in_ff <= I_GENERAL_PURPOSE_PINS;
    end
  end

  assign O_GENERAL_PURPOSE_PINS    = gp_o_ff;
  assign O_GENERAL_PURPOSE_PINS_OE = gp_oe_ff;
  assign O_GP_IN_VAL               = gp_in_ff;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  sequence s_trig;
    I_CONVERT && !conv_q_ff && st_ff == dpc_pkg::DPC_IDLE;
  endsequence
  property p_busy_rise;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN) s_trig |=> O_BUSY;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy not raised"); // RULE_04
  property p_busy_state;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN) O_BUSY == (st_ff == dpc_pkg::DPC_CONV);
  endproperty
  a_busy_state: assert property (p_busy_state) else $error("busy mismatch"); // RULE_05
  property p_dout_oe;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN) $fell(I_CS_N) |=> O_DOUT_OE;
  endproperty
  a_dout_oe: assert property (p_dout_oe) else $error("dout not driven"); // RULE_10
  property p_din_3w;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN) !$past(I_TWO_WIRE) |-> !O_DIN_OE;
  endproperty
  a_din_3w: assert property (p_din_3w) else $error("din driven in 3-wire"); // RULE_08
  property p_din_cs;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN) $past(I_CS_N) |-> !O_DIN_OE && !O_DOUT_OE;
  endproperty
  a_din_cs: assert property (p_din_cs) else $error("pins driven with cs high"); // RULE_12
  property p_din_2w;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
      O_DIN_OE |-> O_DIN == O_DOUT && O_DOUT_OE;
  endproperty
  a_din_2w: assert property (p_din_2w) else $error("din copy wrong"); // RULE_09
  property p_osc_oe;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
      $past(I_CLOCK_SOURCE_SELECT | I_OSCILLATOR_ENABLE_BIT) |-> O_CONVERSION_CLOCK_OE;
  endproperty
  a_osc_oe: assert property (p_osc_oe) else $error("oscillator not driven"); // RULE_17
  property p_conversion_clock_in;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
      !$past(I_CLOCK_SOURCE_SELECT | I_OSCILLATOR_ENABLE_BIT) |-> !O_CONVERSION_CLOCK_OE;
  endproperty
  a_conversion_clock_in: assert property (p_conversion_clock_in) else $error("conversion_clock driven as input"); // RULE_07
  property p_conv_len;
    @(posedge I_CLK_SYS) disable iff (!I_RESETN)
      $fell(O_BUSY) |-> cyc_ff == `DPC_CONV_CYCLES;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // RULE_16
endmodule

// file: verif/dpc_host_model.sv
// ----------------------------------------
// dpc_host_model: host side of the serial port
// ----------------------------------------
// Purpose: drives chip select, serial clock and data in frames
// Assumes: called from the bench right after a rising clock edge
// Notes:   serial clock stands still between frames
module dpc_host_model (
  // clock and mode
  input  wire logic i_clk,
  input  wire logic i_es,
  // serial lines
  input  wire logic i_dout,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din
);
  timeunit 1ns;
  timeprecision 1ns;

  // lines idle with chip select high
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din  = 1'b0;
  end

  // one frame of nb bits msb first; 3-clock phases beat the 2-clock minimum
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    o_sclk <= i_es;
    repeat (2) @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < nb; i++) begin
      o_din  <= tx[7-i];
      o_sclk <= ~i_es;
      repeat (3) @(posedge i_clk);
      rx = {rx[6:0], i_dout};
      o_sclk <= i_es;
      repeat (3) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    o_din  <= ~o_din;                   // released line shows no stale bit
    @(posedge i_clk);
  endtask
endmodule

// file: verif/daq_pin_control_serial_port_tb.sv
// ----------------------------------------
// daq_pin_control_serial_port_tb: self-checking bench
// ----------------------------------------
// Purpose: conversion, clock source, serial port and general pins
// Assumes: 10 MHz system clock, external conversion clock of 4 cycles
// Notes:   shared pin levels resolved here from the DUT enables
module daq_pin_control_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, rst_q, convert, src_sel, osc_bit, tw, es, ext_clk, cs_q;
  logic [1:0] df, ec;
  logic [7:0] tx_word, rx_word;
  logic [3:0] gp_dir, gp_val, gp_ext, gp_out, gp_oe, gp_in;
  logic       busy, conversion_clock_o, conversion_clock_oe, cs_n, sclk, h_din, din_o, din_oe, dout, dout_oe, rxv;
  int         num_errors, cmp_count, seed, rxv_cnt, n, prev;
  wire logic       conversion_clock_line = conversion_clock_oe ? conversion_clock_o : ext_clk;
  wire logic       din_line  = din_oe ? din_o : h_din;
  wire logic [3:0] gp_line   = (gp_oe & gp_out) | (~gp_oe & gp_ext);

  dpc_top DUT (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_CONVERT(convert),
    .I_CLOCK_SOURCE_SELECT(src_sel), .I_OSCILLATOR_ENABLE_BIT(osc_bit),
    .I_CLOCK_DIVIDE_FACTOR(df), .O_BUSY(busy), .I_CONVERSION_CLOCK(conversion_clock_line),
    .O_CONVERSION_CLOCK(conversion_clock_o), .O_CONVERSION_CLOCK_OE(conversion_clock_oe), .I_CS_N(cs_n),
    .I_EDGE_SELECT(es), .I_TWO_WIRE(tw), .I_SCLK(sclk), .I_DIN(din_line),
    .O_DIN(din_o), .O_DIN_OE(din_oe), .O_DOUT(dout), .O_DOUT_OE(dout_oe),
    .I_TX_WORD(tx_word), .O_RX_WORD(rx_word), .O_RX_VALID(rxv),
    .I_GP_DIR_OUT(gp_dir), .I_GP_OUT_VAL(gp_val), .I_GENERAL_PURPOSE_PINS(gp_line),
    .O_GENERAL_PURPOSE_PINS(gp_out), .O_GENERAL_PURPOSE_PINS_OE(gp_oe),
    .O_GP_IN_VAL(gp_in));

  dpc_host_model host (.i_clk(clk), .i_es(es), .i_dout(dout), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_din(h_din));

  // ----------------------------------------
  // clocks, monitors and checks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // external conversion clock, period of 4 system clocks
  always @(posedge clk) begin
    ec      <= ec + 2'h1;
    ext_clk <= ec[1];
    cs_q    <= cs_n;
    rst_q   <= rst_n;
    if (rxv === 1'b1) rxv_cnt <= rxv_cnt + 1;
  end

  // pin enables watched every cycle, clear of reset
  always @(negedge clk) begin
    if (rst_q === 1'b1 && rst_n === 1'b1) begin
      // logical not keeps the expected one bit wide before the size cast
      chk(16'(dout_oe), 16'(!cs_q));
      chk(16'(din_oe), 16'(tw && !cs_q));
      if (din_oe === 1'b1) chk(16'(din_o), 16'(dout));
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounds on conversion clock rises seen while busy (phase slack of one tick)
  function automatic int f_lo(input logic [1:0] f);
    return 13 * (1 << f);
  endfunction
  function automatic int f_hi(input logic [1:0] f);
    return 15 * (1 << f);
  endfunction
  function automatic logic [3:0] f_gp(input logic [3:0] d, v, e);
    return (d & v) | (~d & e);
  endfunction

  // one conversion, with a second trigger while busy that must be ignored
  task automatic run_conv(input logic [1:0] f);
    int   rises;
    int   k;
    logic cp;
    df <= f;
    repeat (2) @(posedge clk);
    convert <= 1'b1;
    k = 0;
    while (busy !== 1'b1 && k < 4) begin
      @(posedge clk);
      k++;
    end
    chk(16'(busy), 16'h0001);
    rises = 0;
    k = 0;
    cp = conversion_clock_line;
    while (busy === 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
      if (k == 2) convert <= 1'b0;
      if (k == 6) convert <= 1'b1;                      // refused while busy
      if (k == 9) convert <= 1'b0;
      if (conversion_clock_line === 1'b1 && cp === 1'b0) rises++;
      cp = conversion_clock_line;
    end
    chk(16'(rises >= f_lo(f) && rises <= f_hi(f)), 16'h0001);
  endtask

  // one serial frame of nb bits in the given edge and wire mode
  task automatic ser(input logic e, input logic w, input int nb);
    logic [7:0] tx, hd, rx;
    int         v0;
    tx = 8'($random(seed));
    hd = 8'($random(seed));
    es <= e;
    tw <= w;
    tx_word <= tx;
    repeat (2) @(posedge clk);
    v0 = rxv_cnt;
    host.xfer(hd, nb, rx);
    repeat (2) @(posedge clk);
    if (nb == 8) begin
      chk(16'(rx), 16'(tx));
      chk(16'(rxv_cnt - v0), 16'h0001);
      chk(16'(rx_word), 16'(w ? tx : hd));
    end else begin
      chk(16'(rxv_cnt - v0), 16'h0000);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    #(100 * 60000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    seed = 627;
    {rst_n, convert, src_sel, osc_bit, tw, es, ext_clk, df, ec} = '0;
    {tx_word, gp_dir, gp_val, gp_ext, num_errors, cmp_count, rxv_cnt} = '0;
    repeat (4) @(posedge clk);
    chk(16'({busy, conversion_clock_oe, rxv, gp_oe, rx_word}), 16'h0000);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      src_sel <= k[0];
      osc_bit <= k[1];
      repeat (3) @(posedge clk);
      n = 0;
      prev = int'(conversion_clock_o);
      repeat (8) begin
        @(posedge clk);
        if (int'(conversion_clock_o) != prev) n++;
        prev = int'(conversion_clock_o);
      end
      chk(16'(conversion_clock_oe), 16'(k != 0));
      if (k != 0) chk(16'(n), 16'h0004);
    end
    $display("test clock source done");
    // config bit off so the random select also runs conversions on the external clock
    osc_bit <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      src_sel <= 1'($random(seed));
      run_conv(2'(k));
    end
    $display("test conversion done");
    for (int k = 0; k < 8; k++) ser(k[0], k[1], (k == 5) ? 4 : 8);
    fork
      run_conv(2'h1);
      ser(1'b1, 1'b0, 8);
    join
    $display("test serial done");
    repeat (8) begin
      gp_dir <= 4'($random(seed));
      gp_val <= 4'($random(seed));
      gp_ext <= 4'($random(seed));
      repeat (4) @(posedge clk);
      chk(16'(gp_oe), 16'(gp_dir));
      chk(16'(gp_out & gp_dir), 16'(gp_val & gp_dir));
      chk(16'(gp_in), 16'(f_gp(gp_dir, gp_val, gp_ext)));
    end
    $display("test general pins done");
    ser(1'b0, 1'b0, 8);
    convert <= 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    chk(16'({busy, rx_word, gp_oe}), 16'h0000);
    rst_n <= 1'b1;
    convert <= 1'b0;
    repeat (3) @(posedge clk);
    $display("test reset done");
    report_and_stop();
  end
endmodule
